// ---- core/sprf_status_bank.sv ----
// receiver status flags and a burst preamble byte (zero for audio data, else preamble-D low or channel-B preamble-C high), read over the control port
`timescale 1ns/100ps
module sprf_status_bank (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire sprf_pkg::sprf_dec_s dec_i,
  input wire logic rd_strobe_i,
  input wire logic [6:0] rd_addr_i,
  output logic [7:0] rd_data_o,
  output logic [7:0] flags_o,
  output logic [7:0] flag_event_o
);
  sprf_pkg::sprf_top_s st_q;
  sprf_pkg::sprf_top_s st_d;
  logic [7:0] live;
  logic [7:0] flag;
  logic [7:0] pre_byte;
  logic rd_flags;

  assign live = {dec_i.received_valid_indicator, dec_i.emphasis, dec_i.nonaudio,
                 dec_i.preamble_detect, dec_i.channel_status_check_fail, dec_i.no_stream,
                 dec_i.biphase_parity_err, dec_i.locked};
  // clearing only on a frozen-free cycle keeps a stalled read from eating errors
  assign rd_flags = ce_i & rd_strobe_i & (rd_addr_i == sprf_pkg::ADDR_FAULT_FLAGS);

  for (genvar b = 0; b < 8; b++) begin : g_flag
    sprf_flag_cell #(
      .STICKY(sprf_pkg::STICKY_MASK[b])
    ) u_cell (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .live_i(live[b]),
      .clr_i(rd_flags),
      .flag_o(flag[b]),
      .event_o(flag_event_o[b])
    );
  end

  always_comb begin
    if (!dec_i.nonaudio) begin
      pre_byte = 8'h00;
    end else if (dec_i.subframe_nonaudio) begin
      pre_byte = dec_i.preamble_c_chan_b[15:8];
    end else begin
      pre_byte = dec_i.preamble_d[7:0];
    end
  end

  always_comb begin
    st_d = st_q;
    if (ce_i && rd_strobe_i) begin
      unique case (rd_addr_i)
        sprf_pkg::ADDR_PREAMBLE_D_LOW: st_d.rdata = pre_byte;
        sprf_pkg::ADDR_FAULT_FLAGS: st_d.rdata = flag;
        default: st_d.rdata = sprf_pkg::UNMAPPED_RDATA;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st_q.rdata <= sprf_pkg::RST_RDATA;
    end else begin
      st_q <= st_d;
    end
  end

  assign rd_data_o = st_q.rdata;
  assign flags_o = flag;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_rd_pre;
    ce_i && rd_strobe_i && rd_addr_i == sprf_pkg::ADDR_PREAMBLE_D_LOW;
  endsequence

  sequence s_crc_then_quiet;
    (ce_i && dec_i.channel_status_check_fail)
      ##1 (ce_i && !dec_i.channel_status_check_fail && !rd_flags) [*2];
  endsequence

  sequence s_bip_then_quiet;
    (ce_i && dec_i.biphase_parity_err)
      ##1 (ce_i && !dec_i.biphase_parity_err && !rd_flags) [*2];
  endsequence

  sequence s_rd_unmapped;
    ce_i && rd_strobe_i && rd_addr_i != sprf_pkg::ADDR_PREAMBLE_D_LOW
      && rd_addr_i != sprf_pkg::ADDR_FAULT_FLAGS;
  endsequence

  // lock steady for a cycle, then read while still steady
  sequence s_lock_steady_read;
    (ce_i && dec_i.locked == flag[sprf_pkg::BIT_LOCK])
      ##1 (rd_flags && dec_i.locked == flag[sprf_pkg::BIT_LOCK]);
  endsequence

  AST_PRE_D_LOW: assert property (
    s_rd_pre and (dec_i.nonaudio && !dec_i.subframe_nonaudio)
      |=> rd_data_o == $past(dec_i.preamble_d[7:0]))
    else $error("preamble byte does not show preamble-D low bits");

  AST_PRE_ZERO: assert property (
    s_rd_pre and !dec_i.nonaudio |=> rd_data_o == 8'h00)
    else $error("preamble byte not zero for audio data");

  AST_PRE_SUBFRAME: assert property (
    s_rd_pre and (dec_i.nonaudio && dec_i.subframe_nonaudio)
      |=> rd_data_o == $past(dec_i.preamble_c_chan_b[15:8]))
    else $error("subframe mode does not show channel-B preamble-C high bits");

  AST_EMPH_EVENT: assert property (
    ce_i && (dec_i.emphasis != flag[sprf_pkg::BIT_EMPHASIS])
      |=> flag_event_o[sprf_pkg::BIT_EMPHASIS]
        && flag[sprf_pkg::BIT_EMPHASIS] == $past(dec_i.emphasis))
    else $error("emphasis change not flagged");

  AST_EMPH_QUIET: assert property (
    (ce_i && dec_i.emphasis == flag[sprf_pkg::BIT_EMPHASIS]) ##1 rd_flags
      |-> !flag_event_o[sprf_pkg::BIT_EMPHASIS])
    else $error("emphasis event without a change");

  AST_PREAMBLE_HOLD: assert property (
    rd_flags && dec_i.preamble_detect == flag[sprf_pkg::BIT_PREAMBLE]
      |=> $stable(flag[sprf_pkg::BIT_PREAMBLE]) && !flag_event_o[sprf_pkg::BIT_PREAMBLE])
    else $error("preamble flag moved on read");

  AST_CRC_STICKY: assert property (
    s_crc_then_quiet |-> flag[sprf_pkg::BIT_CRC])
    else $error("crc error flag lost before read");

  AST_CRC_CLEAR: assert property (
    rd_flags && !dec_i.channel_status_check_fail |=> !flag[sprf_pkg::BIT_CRC])
    else $error("crc error flag not cleared by read");

  AST_LOCK_FOLLOW: assert property (
    ce_i && !dec_i.locked ##1 ce_i && !dec_i.locked
      |-> !flag[sprf_pkg::BIT_LOCK] ##1 !flag[sprf_pkg::BIT_LOCK])
    else $error("lock flag set while unlocked");

  AST_BIPHASE_SET_WINS: assert property (
    rd_flags && dec_i.biphase_parity_err |=> flag[sprf_pkg::BIT_BIPHASE])
    else $error("biphase error lost in clearing read");

  AST_BIPHASE_STICKY: assert property (
    s_bip_then_quiet |-> flag[sprf_pkg::BIT_BIPHASE])
    else $error("biphase error flag lost before read");

  AST_BIPHASE_CLEAR: assert property (
    rd_flags && !dec_i.biphase_parity_err |=> !flag[sprf_pkg::BIT_BIPHASE])
    else $error("biphase error flag not cleared by read");

  AST_CRC_EVENT: assert property (
    ce_i && dec_i.channel_status_check_fail && !flag[sprf_pkg::BIT_CRC]
      |=> flag_event_o[sprf_pkg::BIT_CRC] && flag[sprf_pkg::BIT_CRC])
    else $error("crc error set without an event");

  // a sticky bit that is already up must not keep pulsing
  AST_CRC_EVENT_ONCE: assert property (
    ce_i && flag[sprf_pkg::BIT_CRC] |=> !flag_event_o[sprf_pkg::BIT_CRC])
    else $error("crc error event repeated while flag held");

  AST_EMPH_FOLLOW: assert property (
    ce_i |=> flag[sprf_pkg::BIT_EMPHASIS] == $past(dec_i.emphasis))
    else $error("emphasis flag does not follow the stream");

  AST_PREAMBLE_FOLLOW: assert property (
    ce_i |=> flag[sprf_pkg::BIT_PREAMBLE] == $past(dec_i.preamble_detect))
    else $error("preamble flag does not follow detection");

  AST_PREAMBLE_EVENT: assert property (
    ce_i |=> flag_event_o[sprf_pkg::BIT_PREAMBLE] == $changed(flag[sprf_pkg::BIT_PREAMBLE]))
    else $error("preamble event does not match a change");

  AST_LOCK_EVENT: assert property (
    ce_i |=> flag_event_o[sprf_pkg::BIT_LOCK] == $changed(flag[sprf_pkg::BIT_LOCK]))
    else $error("lock event does not match a change");

  AST_LOCK_READ_HOLD: assert property (
    s_lock_steady_read
      |=> $stable(flag[sprf_pkg::BIT_LOCK]) && !flag_event_o[sprf_pkg::BIT_LOCK])
    else $error("lock flag moved or pulsed on read");

  // valid, nonaudio and no-stream carry no sticky behaviour
  AST_OTHER_FOLLOW: assert property (
    ce_i |=> flag[sprf_pkg::BIT_VALID] == $past(dec_i.received_valid_indicator)
      && flag[sprf_pkg::BIT_NONAUDIO] == $past(dec_i.nonaudio)
      && flag[sprf_pkg::BIT_NOSTREAM] == $past(dec_i.no_stream))
    else $error("live status flag does not follow the stream");

  AST_NONAUDIO_EVENT: assert property (
    ce_i |=> flag_event_o[sprf_pkg::BIT_NONAUDIO] == $changed(flag[sprf_pkg::BIT_NONAUDIO]))
    else $error("nonaudio event does not match a change");

  AST_FLAGS_READ: assert property (
    rd_flags |=> rd_data_o == $past(flags_o))
    else $error("flag byte read does not return the flags");

  AST_UNMAPPED_ZERO: assert property (
    s_rd_unmapped |=> rd_data_o == sprf_pkg::UNMAPPED_RDATA)
    else $error("unmapped read did not return zero");

  AST_RDATA_STANDS: assert property (
    !(ce_i && rd_strobe_i) |=> $stable(rd_data_o))
    else $error("read data moved without a taken read");

  // a frozen cycle may only drop the event pulses
  AST_FROZEN: assert property (
    !ce_i |=> $stable(flags_o) && $stable(rd_data_o) && flag_event_o == 8'h00)
    else $error("state moved while clock enable was low");

  AST_RESET_CLEAR: assert property (
    disable iff (1'b0)
    !rst_n_i |=> flags_o == sprf_pkg::RST_FLAGS && rd_data_o == sprf_pkg::RST_RDATA
      && flag_event_o == 8'h00)
    else $error("outputs not cleared by reset");
endmodule

// ---- core/sprf_pkg.sv ----
// shared constants and carriers for the receiver status flag bank
package sprf_pkg;
  localparam logic [6:0] ADDR_PREAMBLE_D_LOW = 7'h17;
  localparam logic [6:0] ADDR_FAULT_FLAGS = 7'h18;
  localparam int BIT_VALID = 7;
  localparam int BIT_EMPHASIS = 6;
  localparam int BIT_NONAUDIO = 5;
  localparam int BIT_PREAMBLE = 4;
  localparam int BIT_CRC = 3;
  localparam int BIT_NOSTREAM = 2;
  localparam int BIT_BIPHASE = 1;
  localparam int BIT_LOCK = 0;
  // set bits are sticky until read, others follow the decoder
  localparam logic [7:0] STICKY_MASK = 8'h0A;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_RDATA = 8'h00;
  localparam logic [7:0] UNMAPPED_RDATA = 8'h00;

  // status arriving from the stream decoder, synchronous to sys_clk_i
  typedef struct packed {
    logic received_valid_indicator;
    logic emphasis;
    logic nonaudio;
    logic preamble_detect;
    logic channel_status_check_fail;
    logic no_stream;
    logic biphase_parity_err;
    logic locked;
    logic subframe_nonaudio;
    logic [15:0] preamble_d;
    logic [15:0] preamble_c_chan_b;
  } sprf_dec_s;

  typedef struct packed {
    logic flag;
    logic event_pulse;
  } sprf_cell_s;

  typedef struct packed {
    logic [7:0] rdata;
  } sprf_top_s;
endpackage

// ---- core/sprf_flag_cell.sv ----
// one status flag: sticky-until-read or live with change event
`timescale 1ns/100ps
module sprf_flag_cell #(
  parameter bit STICKY = 1'b0
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic live_i,
  input wire logic clr_i,
  output logic flag_o,
  output logic event_o
);
  sprf_pkg::sprf_cell_s st_q;
  sprf_pkg::sprf_cell_s st_d;

  always_comb begin
    st_d = st_q;
    if (ce_i) begin
      if (STICKY) begin
        // a new error in the read cycle survives the clear
        st_d.flag = live_i | (st_q.flag & ~clr_i);
        st_d.event_pulse = live_i & ~st_q.flag;
      end else begin
        // a read leaves the flag alone; only a change raises an event
        st_d.flag = live_i;
        st_d.event_pulse = live_i ^ st_q.flag;
      end
    end else begin
      st_d.event_pulse = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign flag_o = st_q.flag;
  assign event_o = st_q.event_pulse;
endmodule

// ---- core/sprf_fix_note.sv ----
// no logic of its own; the flag bank lives in the other core files

// ---- dv/tb.sv ----
// self-checking bench for the receiver status flag bank
`timescale 1ns/100ps
module tb;
  logic sys_clk_i;
  logic rst_n_i;
  logic ce_i;
  logic rd_strobe_i;
  logic pend;
  logic [6:0] rd_addr_i;
  logic [7:0] rd_data_o;
  logic [7:0] flags_o;
  logic [7:0] flag_event_o;
  logic [7:0] q[$];
  logic [31:0] rnd;
  sprf_pkg::sprf_dec_s dec_i;
  int failures;
  int n_compared;
  int n_ev;
  int ev_base;
  sprf_status_bank i_sprf_status_bank (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .dec_i(dec_i), .rd_strobe_i(rd_strobe_i), .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o),
    .flags_o(flags_o), .flag_event_o(flag_event_o));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  // expectation noted when the strobe goes up
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    @(posedge sys_clk_i);
    rd_strobe_i <= 1'b1;
    rd_addr_i <= a;
    q.push_back(exp);
    @(posedge sys_clk_i);
    rd_strobe_i <= 1'b0;
  endtask
  task automatic report_and_stop;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // read data lands one edge after the taken read
  always @(posedge sys_clk_i) begin
    if (pend && q.size() > 0)
      check(rd_data_o, q.pop_front());
    pend <= rd_strobe_i & ce_i & rst_n_i;
    n_ev <= n_ev + $countones(flag_event_o);
  end
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    rst_n_i = 1'b0;
    ce_i = 1'b1;
    rd_strobe_i = 1'b0;
    rd_addr_i = 7'h00;
    dec_i = '0;
    rnd = 32'hAE1FC5D8;
    failures = 0;
    n_compared = 0;
    cyc(10);
    rst_n_i <= 1'b1;
    rd(sprf_pkg::ADDR_FAULT_FLAGS, 8'h00);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      dec_i.preamble_d <= rnd[15:0];
      dec_i.preamble_c_chan_b <= rnd[31:16];
      dec_i.nonaudio <= i[0];
      dec_i.subframe_nonaudio <= i[1];
      cyc(2);
      rd(sprf_pkg::ADDR_PREAMBLE_D_LOW, !i[0] ? 8'h00 : i[1] ? rnd[31:24] : rnd[7:0]);
    end
    // one-cycle faults must still be caught
    dec_i.nonaudio <= 1'b0;
    dec_i.channel_status_check_fail <= 1'b1;
    dec_i.biphase_parity_err <= 1'b1;
    cyc(1);
    dec_i.channel_status_check_fail <= 1'b0;
    dec_i.biphase_parity_err <= 1'b0;
    cyc(3);
    check(flags_o, 8'h0A);
    rd(sprf_pkg::ADDR_FAULT_FLAGS, 8'h0A);
    rd(sprf_pkg::ADDR_FAULT_FLAGS, 8'h00);
    rd(7'h19, 8'h00);
    // a fault that is live during the clearing read must survive it
    dec_i.biphase_parity_err <= 1'b1;
    rd(sprf_pkg::ADDR_FAULT_FLAGS, 8'h02);
    dec_i.biphase_parity_err <= 1'b0;
    rd(sprf_pkg::ADDR_FAULT_FLAGS, 8'h02);
    rd(sprf_pkg::ADDR_FAULT_FLAGS, 8'h00);
    ev_base = n_ev;
    dec_i.emphasis <= 1'b1;
    dec_i.preamble_detect <= 1'b1;
    dec_i.locked <= 1'b1;
    cyc(4);
    rd(sprf_pkg::ADDR_FAULT_FLAGS, 8'h51);
    cyc(3);
    check(flags_o, 8'h51);
    check(8'(n_ev - ev_base), 8'h03);
    // frozen cycles must neither take a read nor latch a fault
    ce_i <= 1'b0;
    dec_i.channel_status_check_fail <= 1'b1;
    cyc(1);
    rd_strobe_i <= 1'b1;
    rd_addr_i <= sprf_pkg::ADDR_PREAMBLE_D_LOW;
    cyc(1);
    rd_strobe_i <= 1'b0;
    dec_i.channel_status_check_fail <= 1'b0;
    cyc(2);
    ce_i <= 1'b1;
    cyc(2);
    check(flags_o, 8'h51);
    check(rd_data_o, 8'h51);
    check(8'(n_ev - ev_base), 8'h03);
    dec_i.locked <= 1'b0;
    cyc(4);
    check(flags_o, 8'h50);
    check(8'(n_ev - ev_base), 8'h04);
    if (q.size() != 0)
      failures++;
    report_and_stop();
  end
endmodule
